// ===== dtec_consts.vh
// constants for the dual timer/event counter
`ifndef DTEC_CONSTS_VH
`define DTEC_CONSTS_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define DTEC_A_IRQ       8'h0B
`define DTEC_A_C8_VAL    8'h0D
`define DTEC_A_C8_CTL    8'h0E
`define DTEC_A_C16_HI    8'h0F
`define DTEC_A_C16_LO    8'h10
`define DTEC_A_C16_CTL   8'h11
// ----------------------------------------
// control fields
// ----------------------------------------
`define DTEC_PS_HI       2
`define DTEC_PS_LO       0
`define DTEC_EDGE        3
`define DTEC_RUN         4
`define DTEC_CLKSEL      5
`define DTEC_MODE_HI     7
`define DTEC_MODE_LO     6
`define DTEC_MODE_EV     2'h1
`define DTEC_MODE_TM     2'h2
`define DTEC_MODE_PW     2'h3
`define DTEC_CTL_RST     8'h08
// ----------------------------------------
// interrupt control zero fields
// ----------------------------------------
`define DTEC_IE8         2
`define DTEC_IE16        3
`define DTEC_F8          5
`define DTEC_F16         6
`define DTEC_IRQ_MASK    8'h6C
`define DTEC_IRQ_RST     8'h00
// ----------------------------------------
// misc values
// ----------------------------------------
`define DTEC_CNT_RST     16'h0000
`define DTEC_CNT8_RST    8'h00
`define DTEC_DIV4_LAST   2'h3
`define DTEC_PS_MAX      3'h7
`endif

// ===== dtec_top.v
// dual timer/event counter: 8-bit and 16-bit counters with register port
// Function
// - counter zero is 8-bit up-counter, clocked from pin or internal source
// - counter zero clock select bit 5: 0 system clock, 1 internal rc
// - counter one is 16-bit up-counter, clocked from pin or internal source
// - counter one clock select bit 5: 0 system clock/4, 1 internal rc
// - counter zero write loads preload path; read returns current count
// - counter one low write only fills low-byte buffer
// - counter one high write moves byte plus buffer into 16-bit preload
// - high read returns high count, copies low count to buffer; low reads buffer
// - event/timer modes count up to all ones, then reload from preload
// - overflow sets flag bit 5 (zero) or bit 6 (one) of irq control
// - edge bit picks event edge or pulse polarity
// - pulse mode counts between start edge and return, then clears enable
// - finished measurement holds; no restart until enable set again
// - pulse mode counts internal ticks; overflow reloads and flags
// - control bit 4 enables counting; event/timer only software clears it
// - any overflow is a wake-up source
// - cleared interrupt enable blocks overflow interrupt in every mode
// - write while disabled loads counter too; while enabled only preload
// - a read of a counter blocks its clock for that cycle
// - counter zero prescaler bits 2:0 divide by 1..64, 111 also 64
//
// The plain strobed port is this design's own decision.
`include "dtec_consts.vh"

module dtec_top (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    input  wire       c8_pin_i,
    input  wire       c16_pin_i,
    input  wire       rc_osc_i,
    output wire       c8_irq_o,
    output wire       c16_irq_o,
    output reg        wake_o
);

// ----------------------------------------
// helpers
// ----------------------------------------
// prescaler tap: divide by 2^ps, 7 behaves like 6
function presc_hit;
    input [5:0] pc;
    input [2:0] ps;
    reg   [5:0] m;
    begin
        case (ps)
            3'h0:    m = 6'h00;
            3'h1:    m = 6'h01;
            3'h2:    m = 6'h03;
            3'h3:    m = 6'h07;
            3'h4:    m = 6'h0F;
            3'h5:    m = 6'h1F;
            default: m = 6'h3F;
        endcase
        presc_hit = ((pc & m) == m);
    end
endfunction

// strobe qualified by one register address
function addr_hit;
    input       stb;
    input [7:0] a;
    input [7:0] want;
    begin
        addr_hit = stb & (a == want);
    end
endfunction

// accepted edge: stages two and three agree on a level the output does not hold yet
function sync_edge;
    input [2:0] s;
    input       acc;
    input       lvl;
    begin
        sync_edge = (s[1] == s[2]) & (s[2] == lvl) & (acc != lvl);
    end
endfunction

// ----------------------------------------
// input synchronisers
// ----------------------------------------
// three stages; a new level is accepted once stages two and three agree
reg  [2:0]  p8_s_q;
reg  [2:0]  p16_s_q;
reg  [2:0]  rc_s_q;
reg         p8_q;
reg         p16_q;
reg         rc_q;
reg         p8_rise;
reg         p8_fall;
reg         p16_rise;
reg         p16_fall;
reg         rc_tick;

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        p8_s_q  <= 3'h0;
        p16_s_q <= 3'h0;
        rc_s_q  <= 3'h0;
        p8_q    <= 1'b0;
        p16_q   <= 1'b0;
        rc_q    <= 1'b0;
    end else begin
        p8_s_q  <= {p8_s_q[1:0], c8_pin_i};
        p16_s_q <= {p16_s_q[1:0], c16_pin_i};
        rc_s_q  <= {rc_s_q[1:0], rc_osc_i};
        if (p8_s_q[1] == p8_s_q[2]) begin
            p8_q <= p8_s_q[2];
        end
        if (p16_s_q[1] == p16_s_q[2]) begin
            p16_q <= p16_s_q[2];
        end
        if (rc_s_q[1] == rc_s_q[2]) begin
            rc_q <= rc_s_q[2];
        end
    end
end

always @* begin
    p8_rise  = sync_edge(p8_s_q, p8_q, 1'b1);
    p8_fall  = sync_edge(p8_s_q, p8_q, 1'b0);
    p16_rise = sync_edge(p16_s_q, p16_q, 1'b1);
    p16_fall = sync_edge(p16_s_q, p16_q, 1'b0);
    rc_tick  = sync_edge(rc_s_q, rc_q, 1'b1);
end

// ----------------------------------------
// registers and decode
// ----------------------------------------
reg  [7:0]  c8_ctl_q;
reg  [7:0]  c16_ctl_q;
reg  [7:0]  irq_q;
reg  [7:0]  c8_cnt_q;
reg  [7:0]  c8_pre_q;
reg  [15:0] c16_cnt_q;
reg  [15:0] c16_pre_q;
reg  [7:0]  c16_lobuf_q;
reg  [5:0]  c8_pc_q;
reg  [5:0]  c16_pc_q;
reg  [1:0]  div4_q;
reg         c8_meas_q;
reg         c16_meas_q;

wire w8v  = addr_hit(wr_i, addr_i, `DTEC_A_C8_VAL);
wire w8c  = addr_hit(wr_i, addr_i, `DTEC_A_C8_CTL);
wire w16h = addr_hit(wr_i, addr_i, `DTEC_A_C16_HI);
wire w16l = addr_hit(wr_i, addr_i, `DTEC_A_C16_LO);
wire w16c = addr_hit(wr_i, addr_i, `DTEC_A_C16_CTL);
wire wirq = addr_hit(wr_i, addr_i, `DTEC_A_IRQ);
wire r8v  = addr_hit(rd_i, addr_i, `DTEC_A_C8_VAL);
wire r16h = addr_hit(rd_i, addr_i, `DTEC_A_C16_HI);

wire [1:0] c8_mode  = c8_ctl_q[`DTEC_MODE_HI:`DTEC_MODE_LO];
wire [1:0] c16_mode = c16_ctl_q[`DTEC_MODE_HI:`DTEC_MODE_LO];
wire       c8_run   = c8_ctl_q[`DTEC_RUN];
wire       c16_run  = c16_ctl_q[`DTEC_RUN];
wire       c8_edge  = c8_ctl_q[`DTEC_EDGE];
wire       c16_edge = c16_ctl_q[`DTEC_EDGE];

// ----------------------------------------
// clock sources and prescalers
// ----------------------------------------
wire c8_src  = c8_ctl_q[`DTEC_CLKSEL] ? rc_tick : 1'b1;
wire c16_src = c16_ctl_q[`DTEC_CLKSEL] ? rc_tick : (div4_q == `DTEC_DIV4_LAST);

wire c8_pt  = c8_src & presc_hit(c8_pc_q, c8_ctl_q[`DTEC_PS_HI:`DTEC_PS_LO]);
wire c16_pt = c16_src & presc_hit(c16_pc_q, c16_ctl_q[`DTEC_PS_HI:`DTEC_PS_LO]);

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        div4_q   <= 2'h0;
        c8_pc_q  <= 6'h00;
        c16_pc_q <= 6'h00;
    end else begin
        div4_q <= div4_q + 2'h1;
        if (c8_src) begin
            c8_pc_q <= c8_pc_q + 6'h01;
        end
        if (c16_src) begin
            c16_pc_q <= c16_pc_q + 6'h01;
        end
    end
end

// ----------------------------------------
// count enables
// ----------------------------------------
// event edge: 1 falling, 0 rising; pulse start edge: 1 rising, 0 falling
wire c8_ev   = c8_edge ? p8_fall : p8_rise;
wire c16_ev  = c16_edge ? p16_fall : p16_rise;
wire c8_st   = c8_edge ? p8_rise : p8_fall;
wire c16_st  = c16_edge ? p16_rise : p16_fall;
wire c8_pw   = (c8_mode == `DTEC_MODE_PW);
wire c16_pw  = (c16_mode == `DTEC_MODE_PW);
wire c8_done  = c8_pw & c8_run & c8_meas_q & c8_ev;
wire c16_done = c16_pw & c16_run & c16_meas_q & c16_ev;

// read of the counter freezes it for that cycle; the lost tick is accepted
wire c8_inc = c8_run & ~r8v &
              (((c8_mode == `DTEC_MODE_EV) & c8_ev) |
               ((c8_mode == `DTEC_MODE_TM) & c8_pt) |
               (c8_pw & c8_meas_q & ~c8_done & c8_pt));
wire c16_inc = c16_run & ~r16h &
               (((c16_mode == `DTEC_MODE_EV) & c16_ev) |
                ((c16_mode == `DTEC_MODE_TM) & c16_pt) |
                (c16_pw & c16_meas_q & ~c16_done & c16_pt));

wire c8_ov  = c8_inc & (c8_cnt_q == 8'hFF);
wire c16_ov = c16_inc & (c16_cnt_q == 16'hFFFF);

// ----------------------------------------
// control registers and pulse measurement
// ----------------------------------------
reg  [7:0]  c8_ctl_d;
reg  [7:0]  c16_ctl_d;
reg         c8_meas_d;
reg         c16_meas_d;

// a software write wins over the hardware clear of the run bit
always @* begin
    c8_ctl_d   = c8_ctl_q;
    c16_ctl_d  = c16_ctl_q;
    c8_meas_d  = c8_meas_q;
    c16_meas_d = c16_meas_q;
    if (w8c) begin
        c8_ctl_d = wdata_i;
    end else if (c8_done) begin
        c8_ctl_d[`DTEC_RUN] = 1'b0;
    end
    if (w16c) begin
        c16_ctl_d = wdata_i;
    end else if (c16_done) begin
        c16_ctl_d[`DTEC_RUN] = 1'b0;
    end
    if (!c8_pw || !c8_run || c8_done) begin
        c8_meas_d = 1'b0;
    end else if (c8_st) begin
        c8_meas_d = 1'b1;
    end
    if (!c16_pw || !c16_run || c16_done) begin
        c16_meas_d = 1'b0;
    end else if (c16_st) begin
        c16_meas_d = 1'b1;
    end
end

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        c8_ctl_q   <= `DTEC_CTL_RST;
        c16_ctl_q  <= `DTEC_CTL_RST;
        c8_meas_q  <= 1'b0;
        c16_meas_q <= 1'b0;
    end else begin
        c8_ctl_q   <= c8_ctl_d;
        c16_ctl_q  <= c16_ctl_d;
        c8_meas_q  <= c8_meas_d;
        c16_meas_q <= c16_meas_d;
    end
end

// ----------------------------------------
// counters, preloads and low-byte buffer
// ----------------------------------------
reg  [7:0]  c8_cnt_d;
reg  [7:0]  c8_pre_d;
reg  [15:0] c16_cnt_d;
reg  [15:0] c16_pre_d;
reg  [7:0]  c16_lobuf_d;

// a preload write while counting does not disturb the running count
always @* begin
    c8_cnt_d    = c8_cnt_q;
    c8_pre_d    = c8_pre_q;
    c16_cnt_d   = c16_cnt_q;
    c16_pre_d   = c16_pre_q;
    c16_lobuf_d = c16_lobuf_q;
    if (w8v) begin
        c8_pre_d = wdata_i;
    end
    if (w8v && !c8_run) begin
        c8_cnt_d = wdata_i;
    end else if (c8_ov) begin
        c8_cnt_d = c8_pre_q;
    end else if (c8_inc) begin
        c8_cnt_d = c8_cnt_q + 8'h01;
    end
    if (w16l) begin
        c16_lobuf_d = wdata_i;
    end else if (r16h) begin
        c16_lobuf_d = c16_cnt_q[7:0];
    end
    if (w16h) begin
        c16_pre_d = {wdata_i, c16_lobuf_q};
    end
    if (w16h && !c16_run) begin
        c16_cnt_d = {wdata_i, c16_lobuf_q};
    end else if (c16_ov) begin
        c16_cnt_d = c16_pre_q;
    end else if (c16_inc) begin
        c16_cnt_d = c16_cnt_q + 16'h0001;
    end
end

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        c8_cnt_q    <= `DTEC_CNT8_RST;
        c8_pre_q    <= `DTEC_CNT8_RST;
        c16_cnt_q   <= `DTEC_CNT_RST;
        c16_pre_q   <= `DTEC_CNT_RST;
        c16_lobuf_q <= `DTEC_CNT8_RST;
    end else begin
        c8_cnt_q    <= c8_cnt_d;
        c8_pre_q    <= c8_pre_d;
        c16_cnt_q   <= c16_cnt_d;
        c16_pre_q   <= c16_pre_d;
        c16_lobuf_q <= c16_lobuf_d;
    end
end

// ----------------------------------------
// interrupt control zero, wake-up
// ----------------------------------------
// hardware set wins over a software clear in the same cycle
reg [7:0] irq_d;
always @* begin
    irq_d = wirq ? (wdata_i & `DTEC_IRQ_MASK) : irq_q;
    if (c8_ov) begin
        irq_d[`DTEC_F8] = 1'b1;
    end
    if (c16_ov) begin
        irq_d[`DTEC_F16] = 1'b1;
    end
end

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        irq_q  <= `DTEC_IRQ_RST;
        wake_o <= 1'b0;
    end else begin
        irq_q  <= irq_d;
        wake_o <= c8_ov | c16_ov;
    end
end

assign c8_irq_o  = irq_q[`DTEC_F8] & irq_q[`DTEC_IE8];
assign c16_irq_o = irq_q[`DTEC_F16] & irq_q[`DTEC_IE16];

// ----------------------------------------
// read data
// ----------------------------------------
// unmapped addresses read zero
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        rdata_o <= 8'h00;
    end else if (rd_i) begin
        case (addr_i)
            `DTEC_A_IRQ:     rdata_o <= irq_q;
            `DTEC_A_C8_VAL:  rdata_o <= c8_cnt_q;
            `DTEC_A_C8_CTL:  rdata_o <= c8_ctl_q;
            `DTEC_A_C16_HI:  rdata_o <= c16_cnt_q[15:8];
            `DTEC_A_C16_LO:  rdata_o <= c16_lobuf_q;
            `DTEC_A_C16_CTL: rdata_o <= c16_ctl_q;
            default:         rdata_o <= 8'h00;
        endcase
    end else begin
        rdata_o <= 8'h00;
    end
end

endmodule // dtec_top

// ===== dtec_props.sv
// assertion checker for the dual timer/event counter ports
module dtec_props (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       c8_pin_i,
    input wire logic       c16_pin_i,
    input wire logic       rc_osc_i,
    input wire logic       c8_irq_o,
    input wire logic       c16_irq_o,
    input wire logic       wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----------------------------------------
    // register port and flags
    // ----------------------------------------
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    a_c8_mask: assert property (wr_i && addr_i == 8'h0B && !wdata_i[2] |=> !c8_irq_o)
        else $error("masked counter zero irq");
    a_c16_mask: assert property (wr_i && addr_i == 8'h0B && !wdata_i[3] |=> !c16_irq_o)
        else $error("masked counter one irq");
    // pulse mode excluded: hardware may drop the run bit
    a_c8_ctl_back: assert property (
        (wr_i && addr_i == 8'h0E && wdata_i[7:6] != 2'h3) ##2 (rd_i && addr_i == 8'h0E)
        |=> rdata_o == $past(wdata_i, 3)) else $error("control zero readback");
    a_c16_ctl_back: assert property (
        (wr_i && addr_i == 8'h11 && wdata_i[7:6] != 2'h3) ##2 (rd_i && addr_i == 8'h11)
        |=> rdata_o == $past(wdata_i, 3)) else $error("control one readback");
    a_low_buffer: assert property (
        (wr_i && addr_i == 8'h10) ##2 (rd_i && addr_i == 8'h10)
        |=> rdata_o == $past(wdata_i, 3)) else $error("low buffer readback");
    a_flag_hold: assert property (
        (wr_i && addr_i == 8'h0B && wdata_i[6:5] == 2'h3) ##2 (rd_i && addr_i == 8'h0B)
        |=> rdata_o == ($past(wdata_i, 3) & 8'h6C)) else $error("irq register readback");
    a_wake_after: assert property ($rose(c8_irq_o) && !$past(wr_i) |-> wake_o)
        else $error("overflow without wake pulse");
endmodule // dtec_props

bind dtec_top dtec_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .c8_pin_i(c8_pin_i),
    .c16_pin_i(c16_pin_i), .rc_osc_i(rc_osc_i), .c8_irq_o(c8_irq_o),
    .c16_irq_o(c16_irq_o), .wake_o(wake_o));

// ===== dtec_pin_model.sv
// external pin and rc oscillator model for the counters
module dtec_pin_model (
    input  wire logic clk_i,
    output logic      c8_pin_o,
    output logic      c16_pin_o,
    output logic      rc_osc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int ph;
    initial begin
        c8_pin_o = 1'b0;
        c16_pin_o = 1'b0;
        rc_osc_o = 1'b0;
        ph = 0;
    end
    // free running, one rising edge every 6 clocks
    always @(posedge clk_i) begin
        ph <= (ph == 2) ? 0 : ph + 1;
        if (ph == 2) rc_osc_o <= ~rc_osc_o;
    end
    // both levels held w clocks, never under 3 so the sync stages agree
    task automatic pulse(input bit k, input int w);
        @(posedge clk_i);
        if (k) c16_pin_o <= 1'b1; else c8_pin_o <= 1'b1;
        repeat (w) @(posedge clk_i);
        if (k) c16_pin_o <= 1'b0; else c8_pin_o <= 1'b0;
        repeat (w) @(posedge clk_i);
    endtask
endmodule // dtec_pin_model

// ===== dtec_top_tb.sv
// self-checking bench for the dual timer/event counter
module dtec_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v;
    logic       c8_pin_i, c16_pin_i, rc_osc_i, c8_irq_o, c16_irq_o, wake_o;
    int         bad_count = 0, checks_done = 0, cyc = 0, n, i;
    always #5 clk_i = ~clk_i;
    dtec_pin_model u_pins (.clk_i(clk_i), .c8_pin_o(c8_pin_i), .c16_pin_o(c16_pin_i),
        .rc_osc_o(rc_osc_i));
    dtec_top u_dtec_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .c8_pin_i(c8_pin_i), .c16_pin_i(c16_pin_i), .rc_osc_i(rc_osc_i),
        .c8_irq_o(c8_irq_o), .c16_irq_o(c16_irq_o), .wake_o(wake_o));
    // ----------------------------------------
    // bus tasks and compare
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rdv(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rdv(a);
        chk(v, exp);
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // two ticks of period t from all ones minus one; free prescaler blurs the first
    task automatic tmr(input bit k, input logic [7:0] c, input int t);
        wr(k ? 8'h11 : 8'h0E, 8'h00);
        if (k) wr(8'h10, 8'hFE);
        wr(k ? 8'h0F : 8'h0D, k ? 8'hFF : 8'hFE);
        wr(8'h0B, k ? 8'h08 : 8'h04);
        wr(k ? 8'h11 : 8'h0E, c);
        n = 0;
        while ((k ? c16_irq_o : c8_irq_o) !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(8'(n + 1 >= t && n <= 2 * t + 6), 8'h01);
        chk({7'h00, wake_o}, 8'h01);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(8'h0E, 8'h08);
        rdc(8'h11, 8'h08);
        rdc(8'h0B, 8'h00);
        rdc(8'h00, 8'h00);
        wr(8'h0E, 8'h25);
        rdc(8'h0E, 8'h25);
        wr(8'h0D, 8'h5A);
        rdc(8'h0D, 8'h5A);
        wr(8'h11, 8'h2F);
        rdc(8'h11, 8'h2F);
        wr(8'h0B, 8'h7F);
        rdc(8'h0B, 8'h6C);
        wr(8'h10, 8'h34);
        rdc(8'h10, 8'h34);
        rdc(8'h0F, 8'h00);
        rdc(8'h10, 8'h00);
        wr(8'h10, 8'h34);
        wr(8'h0F, 8'h12);
        rdc(8'h0F, 8'h12);
        rdc(8'h10, 8'h34);
        for (i = 0; i < 8; i++) tmr(0, 8'h90 | 8'(i), 1 << (i == 7 ? 6 : i));
        tmr(0, 8'hB0, 6);
        tmr(1, 8'h91, 8);
        tmr(1, 8'hB0, 6);
        wr(8'h0B, 8'h00);
        repeat (30) @(posedge clk_i);
        chk({6'h00, c16_irq_o, c8_irq_o}, 8'h00);
        rdc(8'h0B, 8'h60);
        wr(8'h0E, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h0D, 8'h00);
        wr(8'h0E, 8'h50);
        for (i = 0; i < 3; i++) u_pins.pulse(0, 4);
        rdc(8'h0D, 8'h03);
        wr(8'h0E, 8'h58);
        for (i = 0; i < 2; i++) u_pins.pulse(0, 4);
        rdc(8'h0D, 8'h05);
        wr(8'h0E, 8'h00);
        wr(8'h0D, 8'h00);
        wr(8'h0E, 8'hD8);
        u_pins.pulse(0, 20);
        rdc(8'h0E, 8'hC8);
        chk(8'(v == 8'hC8), 8'h01);
        rdv(8'h0D);
        chk(8'(v >= 8'd17 && v <= 8'd22), 8'h01);
        n = v;
        u_pins.pulse(0, 20);
        rdc(8'h0D, 8'(n));
        print_verdict();
    end
endmodule // dtec_top_tb
